// file: design/led_pd_pkg.sv
// constants for the led and iris power-down register block
// assumes a single system oscillator clock domain and 16-bit registers
package led_pd_pkg;

    // ------------------------------------------------------------
    // serial frame layout
    // ------------------------------------------------------------
    localparam int unsigned ADDR_BITS = 6;
    localparam int unsigned DATA_BITS = 16;
    localparam int unsigned RW_POS = 6;
    localparam logic [4:0] DATA_START = 5'h08;
    localparam logic [4:0] FRAME_LAST = 5'h17;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [5:0] IRIS_CTL_ADDR = 6'h0b;
    localparam logic [5:0] LED_B_ADDR = 6'h24;
    localparam logic [5:0] LED_A_ADDR = 6'h29;

    // ------------------------------------------------------------
    // field positions and reset values
    // ------------------------------------------------------------
    localparam int unsigned LED_POS = 0;
    localparam int unsigned IRIS_EN_POS = 10;
    localparam logic [15:0] LED_RESET = 16'h0000;
    localparam logic [15:0] IRIS_CTL_RESET = 16'h0000;

    // ------------------------------------------------------------
    // serial receiver states
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        SER_IDLE = 2'b00,
        SER_HEAD = 2'b01,
        SER_DATA = 2'b11,
        SER_DONE = 2'b10
    } ser_state_t;

endpackage

// file: design/sync_2ff.sv
// two-flop synchroniser for asynchronous level inputs
// assumes the destination clock is the system oscillator clock
`timescale 1ns/1ns
module sync_2ff #(
    parameter int unsigned WIDTH = 2
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // levels
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_q
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= async_in;
            sync_q <= meta_q;
        end
    end

endmodule

// file: design/led_powerdown_control.sv
// led switch and iris power-down register block with its serial slave
// assumes serial pins and motor step are synchronous to clk_sys
//
// Functional notes
// RULE1: led a control at 29h, led b at 24h, both serially writable.
// RULE2: each led bit drives its own switch; 0 off, 1 on.
// RULE3: serial input is taken only on oscillator clock edges.
// RULE4: both vsync inputs are resynchronised to the oscillator clock.
// RULE5: writing 0 to the iris enable bit enters power-down.
// RULE6: power-down halts the iris analog drive path.
// RULE7: power-down leaves the micro-step motor driver untouched.
// RULE8: host should write 0 to iris enable when only motor is used.
// RULE9: iris enable bit sits at 0Bh, resets 0; 1 enables iris.
// RULE10: both led bits read 0 after reset, leds start off.
`timescale 1ns/1ns
module led_powerdown_control (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // serial register port
    input wire logic ser_cs,
    input wire logic ser_sclk,
    input wire logic ser_sdata_in,
    output logic ser_sdata_out_q,
    output logic ser_sdata_oe_q,
    // vsync inputs and their resynchronised copies
    input wire logic vsync_focus_input,
    input wire logic vsync_iris_input,
    output logic vsync_focus_sync_q,
    output logic vsync_iris_sync_q,
    // motor step path
    input wire logic motor_step_in,
    output logic motor_step_q,
    // outputs
    output logic led_a_switch_q,
    output logic led_b_switch_q,
    output logic iris_analog_run_q
);

    // ------------------------------------------------------------
    // vsync resynchronisation
    // ------------------------------------------------------------
    // RULE4: two-flop synchroniser
    sync_2ff #(
        .WIDTH(2)
    ) u_vsync_sync (
        .clk_sys(clk_sys),
        .rst(rst),
        .async_in({vsync_iris_input, vsync_focus_input}),
        .sync_q({vsync_iris_sync_q, vsync_focus_sync_q})
    );

    // ------------------------------------------------------------
    // serial receiver
    // ------------------------------------------------------------
    led_pd_pkg::ser_state_t state_q;
    logic sclk_prev_q;
    logic [4:0] bit_cnt_q;
    logic [led_pd_pkg::ADDR_BITS-1:0] addr_q;
    logic rd_q;
    logic [led_pd_pkg::DATA_BITS-1:0] wdata_q;
    logic [led_pd_pkg::DATA_BITS-1:0] rdata_q;
    logic sclk_rise;
    logic sclk_fall;
    logic wr_commit;
    logic [led_pd_pkg::DATA_BITS-1:0] wr_data;
    logic [15:0] led_a_ctl_q;
    logic [15:0] led_b_ctl_q;
    logic [15:0] iris_ctl_q;

    function automatic logic [15:0] read_mux(input logic [5:0] a, input logic [15:0] la,
                                             input logic [15:0] lb, input logic [15:0] ir);
        case (a)
            led_pd_pkg::LED_A_ADDR: read_mux = la;
            led_pd_pkg::LED_B_ADDR: read_mux = lb;
            led_pd_pkg::IRIS_CTL_ADDR: read_mux = ir;
            default: read_mux = 16'h0000;
        endcase
    endfunction

    // RULE3: sclk edges are seen only through clk_sys sampling
    assign sclk_rise = ser_sclk && !sclk_prev_q;
    assign sclk_fall = !ser_sclk && sclk_prev_q;
    assign wr_data = {ser_sdata_in, wdata_q[led_pd_pkg::DATA_BITS-1:1]};
    assign wr_commit = (state_q == led_pd_pkg::SER_DATA) && sclk_rise && !rd_q &&
                       (bit_cnt_q == led_pd_pkg::FRAME_LAST);

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_prev_q <= ser_sclk;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_q <= led_pd_pkg::SER_IDLE;
            bit_cnt_q <= 5'h00;
            addr_q <= '0;
            rd_q <= 1'b0;
            wdata_q <= '0;
        end else if (!ser_cs) begin
            state_q <= led_pd_pkg::SER_IDLE;
            bit_cnt_q <= 5'h00;
        end else begin
            case (state_q)
                led_pd_pkg::SER_IDLE: begin
                    state_q <= led_pd_pkg::SER_HEAD;
                    bit_cnt_q <= 5'h00;
                end
                led_pd_pkg::SER_HEAD: begin
                    if (sclk_rise) begin
                        if (bit_cnt_q < 5'(led_pd_pkg::ADDR_BITS)) begin
                            addr_q <= {ser_sdata_in, addr_q[led_pd_pkg::ADDR_BITS-1:1]};
                        end
                        if (bit_cnt_q == 5'(led_pd_pkg::RW_POS)) begin
                            rd_q <= ser_sdata_in;
                        end
                        if (bit_cnt_q == led_pd_pkg::DATA_START - 5'h01) begin
                            state_q <= led_pd_pkg::SER_DATA;
                        end
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                    end
                end
                led_pd_pkg::SER_DATA: begin
                    if (sclk_rise) begin
                        wdata_q <= wr_data;
                        if (bit_cnt_q == led_pd_pkg::FRAME_LAST) begin
                            state_q <= led_pd_pkg::SER_DONE;
                        end
                        bit_cnt_q <= bit_cnt_q + 5'h01;
                    end
                end
                led_pd_pkg::SER_DONE: begin
                    state_q <= led_pd_pkg::SER_DONE;
                end
                default: begin
                    state_q <= led_pd_pkg::SER_IDLE;
                end
            endcase
        end
    end

    // read data shifted out lsb first on sclk falling edges
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rdata_q <= '0;
            ser_sdata_out_q <= 1'b0;
            ser_sdata_oe_q <= 1'b0;
        end else if (!ser_cs || state_q == led_pd_pkg::SER_DONE) begin
            ser_sdata_oe_q <= 1'b0;
            ser_sdata_out_q <= 1'b0;
        end else if (state_q == led_pd_pkg::SER_HEAD && sclk_rise &&
                     bit_cnt_q == led_pd_pkg::DATA_START - 5'h01) begin
            rdata_q <= read_mux(addr_q, led_a_ctl_q, led_b_ctl_q, iris_ctl_q);
        end else if (state_q == led_pd_pkg::SER_DATA && rd_q && sclk_fall) begin
            ser_sdata_oe_q <= 1'b1;
            ser_sdata_out_q <= rdata_q[0];
            rdata_q <= {1'b0, rdata_q[led_pd_pkg::DATA_BITS-1:1]};
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // RULE1: led controls at their two offsets
    // RULE10: both led controls reset to off
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            led_a_ctl_q <= led_pd_pkg::LED_RESET;
            led_b_ctl_q <= led_pd_pkg::LED_RESET;
        end else if (wr_commit) begin
            if (addr_q == led_pd_pkg::LED_A_ADDR) begin
                led_a_ctl_q <= wr_data;
            end
            if (addr_q == led_pd_pkg::LED_B_ADDR) begin
                led_b_ctl_q <= wr_data;
            end
        end
    end

    // RULE9: iris control at 0Bh, reset disabled
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            iris_ctl_q <= led_pd_pkg::IRIS_CTL_RESET;
        end else if (wr_commit && addr_q == led_pd_pkg::IRIS_CTL_ADDR) begin
            iris_ctl_q <= wr_data;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // RULE2: led switches follow their bits
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            led_a_switch_q <= 1'b0;
            led_b_switch_q <= 1'b0;
        end else begin
            led_a_switch_q <= led_a_ctl_q[led_pd_pkg::LED_POS];
            led_b_switch_q <= led_b_ctl_q[led_pd_pkg::LED_POS];
        end
    end

    // RULE5: enable bit low means power-down
    // RULE6: iris analog path halted
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            iris_analog_run_q <= 1'b0;
        end else begin
            iris_analog_run_q <= iris_ctl_q[led_pd_pkg::IRIS_EN_POS];
        end
    end

    // RULE7: motor path ignores power-down
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            motor_step_q <= 1'b0;
        end else begin
            motor_step_q <= motor_step_in;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_write(logic [5:0] a);
        wr_commit && addr_q == a;
    endsequence

    property p_led_a_write;
        @(posedge clk_sys) disable iff (rst)
        s_write(led_pd_pkg::LED_A_ADDR) |=> led_a_ctl_q == $past(wr_data);
    endproperty
    a_led_a_write: assert property (p_led_a_write) else $error("led a write lost"); // RULE1

    property p_led_b_switch;
        @(posedge clk_sys) disable iff (rst)
        s_write(led_pd_pkg::LED_B_ADDR) |-> ##2 led_b_switch_q == $past(wr_data[0], 2);
    endproperty
    a_led_b_switch: assert property (p_led_b_switch) else $error("led b switch wrong"); // RULE2

    property p_led_a_switch;
        @(posedge clk_sys) disable iff (rst)
        s_write(led_pd_pkg::LED_A_ADDR) |-> ##2 led_a_switch_q == $past(wr_data[0], 2);
    endproperty
    a_led_a_switch: assert property (p_led_a_switch) else $error("led a switch wrong"); // RULE2

    property p_serial_on_clock;
        @(posedge clk_sys) disable iff (rst)
        (bit_cnt_q != $past(bit_cnt_q) && $past(ser_cs)) |-> $past(sclk_rise);
    endproperty
    a_serial_on_clock: assert property (p_serial_on_clock) else $error("stray bit count"); // RULE3

    property p_vsync_sync;
        @(posedge clk_sys) disable iff (rst)
        ##2 vsync_iris_sync_q == $past(vsync_iris_input, 2);
    endproperty
    a_vsync_sync: assert property (p_vsync_sync) else $error("vsync sync delay wrong"); // RULE4

    property p_power_down_write;
        @(posedge clk_sys) disable iff (rst)
        s_write(led_pd_pkg::IRIS_CTL_ADDR) ##0 !wr_data[led_pd_pkg::IRIS_EN_POS]
            |-> ##2 !iris_analog_run_q;
    endproperty
    a_power_down_write: assert property (p_power_down_write) else $error("no power-down"); // RULE5

    property p_iris_halted;
        @(posedge clk_sys) disable iff (rst)
        !iris_ctl_q[led_pd_pkg::IRIS_EN_POS] |=> !iris_analog_run_q;
    endproperty
    a_iris_halted: assert property (p_iris_halted) else $error("iris runs in power-down"); // RULE6

    property p_motor_free;
        @(posedge clk_sys) disable iff (rst)
        !iris_ctl_q[led_pd_pkg::IRIS_EN_POS] |=> motor_step_q == $past(motor_step_in);
    endproperty
    a_motor_free: assert property (p_motor_free) else $error("motor gated in power-down"); // RULE7

    property p_iris_reset;
        @(posedge clk_sys) $fell(rst) |->
            !iris_ctl_q[led_pd_pkg::IRIS_EN_POS] && !iris_analog_run_q;
    endproperty
    a_iris_reset: assert property (p_iris_reset) else $error("iris not off after reset"); // RULE9

    property p_led_reset;
        @(posedge clk_sys) $fell(rst) |->
            !led_a_switch_q && !led_b_switch_q && led_a_ctl_q == 16'h0000;
    endproperty
    a_led_reset: assert property (p_led_reset) else $error("leds not off after reset"); // RULE10

endmodule

// file: verif/host_serial_model.sv
// host controller model: serial master for the register port
// assumes clk_sys keeps running; frames are started by bench calls
`timescale 1ns/1ns
module host_serial_model (
    // clock
    input wire logic clk_sys,
    // device answer
    input wire logic dev_sdata_out,
    input wire logic dev_sdata_oe,
    // serial lines
    output logic ser_cs,
    output logic ser_sclk,
    output logic ser_sdata
);
    // ------------------------------------------------------------
    // data line
    // ------------------------------------------------------------
    logic host_drive;
    logic host_bit;

    initial begin
        ser_cs = 1'b0;
        ser_sclk = 1'b0;
        host_drive = 1'b0;
        host_bit = 1'b0;
    end

    // released line shows the inverse of the last host bit
    assign ser_sdata = dev_sdata_oe ? dev_sdata_out : (host_drive ? host_bit : ~host_bit);

    // ------------------------------------------------------------
    // frame tasks
    // ------------------------------------------------------------
    // frames paced by clk_sys
    task automatic xfer(input logic rd, input logic [5:0] addr, input logic [15:0] wdata,
                        input int nbits, input int half, output logic [15:0] rdata);
        logic [23:0] frame;
        frame = {wdata, 1'b0, rd, addr};
        rdata = 16'h0000;
        @(posedge clk_sys);
        ser_cs <= 1'b1;
        host_drive <= 1'b1;
        repeat (2) @(posedge clk_sys);
        for (int i = 0; i < nbits; i++) begin
            ser_sclk <= 1'b0;
            host_bit <= frame[i];
            if (rd && i >= 8) begin
                host_drive <= 1'b0;
            end
            repeat (half - 1) @(posedge clk_sys);
            @(negedge clk_sys);
            if (rd && i >= 8) begin
                rdata[i-8] = ser_sdata;
            end
            @(posedge clk_sys);
            ser_sclk <= 1'b1;
            repeat (half) @(posedge clk_sys);
        end
        ser_sclk <= 1'b0;
        repeat (2) @(posedge clk_sys);
        ser_cs <= 1'b0;
        host_drive <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask

    task automatic motor_only();
        logic [15:0] unused;
        xfer(1'b0, led_pd_pkg::IRIS_CTL_ADDR, 16'h0000, 24, 3, unused);
    endtask
endmodule

// file: verif/led_powerdown_control_tb_top.sv
// self-checking bench for the led and iris power-down block
// assumes the host model in host_serial_model drives the serial port
`timescale 1ns/1ns
module led_powerdown_control_tb_top;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    logic clk_sys, rst, ser_cs, ser_sclk, ser_sdata_in, sdo, soe;
    logic vf, vi, vfs, vis, step_in, step_q, led_a, led_b, iris_run;
    int bad_count;
    int samples_checked;
    int cycles;
    logic [15:0] rd;

    initial clk_sys = 1'b0;
    always #4 clk_sys = ~clk_sys;

    led_powerdown_control dut (
        .clk_sys(clk_sys), .rst(rst), .ser_cs(ser_cs), .ser_sclk(ser_sclk),
        .ser_sdata_in(ser_sdata_in), .ser_sdata_out_q(sdo), .ser_sdata_oe_q(soe),
        .vsync_focus_input(vf), .vsync_iris_input(vi), .vsync_focus_sync_q(vfs),
        .vsync_iris_sync_q(vis), .motor_step_in(step_in), .motor_step_q(step_q),
        .led_a_switch_q(led_a), .led_b_switch_q(led_b), .iris_analog_run_q(iris_run)
    );

    host_serial_model host (
        .clk_sys(clk_sys), .dev_sdata_out(sdo), .dev_sdata_oe(soe),
        .ser_cs(ser_cs), .ser_sclk(ser_sclk), .ser_sdata(ser_sdata_in)
    );

    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic end_sim();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic ochk(input logic [15:0] exp);
        @(negedge clk_sys);
        chk("outputs", exp, {13'h0000, iris_run, led_b, led_a});
    endtask

    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        logic [15:0] unused;
        host.xfer(1'b0, a, d, 24, 3, unused);
    endtask

    task automatic rchk(input string what, input logic [5:0] a, input logic [15:0] exp);
        logic [15:0] got;
        host.xfer(1'b1, a, 16'h0000, 24, 3, got);
        chk(what, exp, got);
    endtask

    task automatic step_chk(input logic v);
        logic old;
        old = step_in;
        @(posedge clk_sys);
        step_in <= v;
        @(negedge clk_sys);
        chk("step_early", {15'h0000, old}, {15'h0000, step_q});
        @(negedge clk_sys);
        chk("step", {15'h0000, v}, {15'h0000, step_q});
    endtask

    task automatic vs_chk(input logic f, input logic i);
        logic [1:0] old;
        old = {vf, vi};
        @(posedge clk_sys);
        vf <= f;
        vi <= i;
        repeat (2) @(negedge clk_sys);
        chk("vsync_early", {14'h0000, old}, {14'h0000, vfs, vis});
        @(negedge clk_sys);
        chk("vsync", {14'h0000, f, i}, {14'h0000, vfs, vis});
    endtask

    // hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            end_sim();
        end
    end

    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        vf = 1'b0;
        vi = 1'b0;
        step_in = 1'b0;
        bad_count = 0;
        samples_checked = 0;
        cycles = 0;
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        @(posedge clk_sys);
        ochk(16'h0000);
        rchk("led_a_reg", led_pd_pkg::LED_A_ADDR, 16'h0000);
        rchk("led_b_reg", led_pd_pkg::LED_B_ADDR, 16'h0000);
        rchk("iris_reg", led_pd_pkg::IRIS_CTL_ADDR, 16'h0000);
        wr(led_pd_pkg::LED_A_ADDR, 16'h0001);
        ochk(16'h0001);
        wr(led_pd_pkg::LED_B_ADDR, 16'ha5c3);
        ochk(16'h0003);
        wr(led_pd_pkg::LED_A_ADDR, 16'hfffe);
        ochk(16'h0002);
        rchk("led_b_reg", led_pd_pkg::LED_B_ADDR, 16'ha5c3);
        rchk("led_a_reg", led_pd_pkg::LED_A_ADDR, 16'hfffe);
        // cut frame must write nothing
        host.xfer(1'b0, led_pd_pkg::LED_A_ADDR, 16'h0001, 20, 3, rd);
        ochk(16'h0002);
        wr(6'h3f, 16'hffff);
        ochk(16'h0002);
        rchk("unmapped", 6'h3f, 16'h0000);
        // slow serial clock
        host.xfer(1'b0, led_pd_pkg::LED_B_ADDR, 16'h0000, 24, 7, rd);
        ochk(16'h0000);
        wr(led_pd_pkg::IRIS_CTL_ADDR, 16'h0400);
        ochk(16'h0004);
        step_chk(1'b1);
        step_chk(1'b0);
        host.motor_only();
        ochk(16'h0000);
        rchk("iris_reg", led_pd_pkg::IRIS_CTL_ADDR, 16'h0000);
        step_chk(1'b1);
        step_chk(1'b0);
        vs_chk(1'b1, 1'b0);
        vs_chk(1'b0, 1'b1);
        vs_chk(1'b0, 1'b0);
        end_sim();
    end
endmodule
